// file: crw_pkg.sv
package crw_pkg;
  localparam int CRW_NUM_CH = 2;
  localparam int CRW_TX_SLICE_W = 22;
  localparam int CRW_RX_SLICE_W = 32;
  localparam int CRW_WORD_W = 16;
  localparam int CRW_NUM_WORDS = 16;
  localparam int CRW_WIDX_W = 4;
  localparam int CRW_CH_SEL_W = 1;
  localparam int CRW_BUF_DEPTH = 2;

  // Interface width codes
  localparam logic [1:0] CRW_IF_8 = 2'h0;
  localparam logic [1:0] CRW_IF_10 = 2'h1;
  localparam logic [1:0] CRW_IF_16 = 2'h2;
  localparam logic [1:0] CRW_IF_20 = 2'h3;

  // Wide transmit slice field positions
  localparam int CRW_LO_DATA_LSB = 0;
  localparam int CRW_LO_CTRL_BIT = 8;
  localparam int CRW_LO_FDSP_BIT = 9;
  localparam int CRW_LO_DVAL_BIT = 10;
  localparam int CRW_HI_DATA_LSB = 11;
  localparam int CRW_HI_CTRL_BIT = 19;
  localparam int CRW_HI_FDSP_BIT = 20;
  localparam int CRW_HI_DVAL_BIT = 21;

  localparam logic [CRW_WIDX_W-1:0] CRW_WIDX_RST = 4'h0;

  typedef enum logic [2:0] {
    CRW_ST_IDLE = 3'b001,
    CRW_ST_SEND = 3'b010,
    CRW_ST_WAIT = 3'b100
  } crw_state_t;
endpackage

// file: crw_skid_buf.sv
`timescale 1ns/1ps
// Two-entry buffer; ready on the fill side drops only when both entries are used
module crw_skid_buf
  import crw_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  logic [W-1:0] mem_r [CRW_BUF_DEPTH];
  logic [W-1:0] mem_nxt [CRW_BUF_DEPTH];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    push = i_valid && (cnt_r != 2'h2);
    pop = (cnt_r != 2'h0) && i_ready;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wp_r] = i_data;
    end
    wp_nxt = push ? ~wp_r : wp_r;
    rp_nxt = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data = mem_r[rp_r];

  AST_NO_OVERFLOW: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    cnt_r <= 2'h2) else $error("buffer count beyond depth");
endmodule

// file: crw_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Reconfiguration is write-only; a read request is ignored and flagged.
// - In continuous mode one write-all pulse streams every word without retrigger.
// - Stored contents go to the selected channel as 16-bit words.
// - Words target the channel PCS and receive PMA settings.
// - Wide transmit word is 22 bits per channel.
// - Wide receive word is 32 bits per channel.
// - Transmit word only for tx/duplex; receive word only for rx/duplex.
// - Busy stays high through a write and drops when it completes.
module crw_top
  import crw_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_write_all,
  input wire logic i_read,
  input wire logic i_cont_mode,
  input wire logic [CRW_CH_SEL_W-1:0] i_ch_sel,
  input wire logic [CRW_WORD_W-1:0] i_cfg_word,
  input wire logic [CRW_WIDX_W-1:0] i_cfg_addr,
  input wire logic i_cfg_we,
  input wire logic [1:0] i_if_width,
  input wire logic i_enc_8b10b,
  input wire logic i_tx_en,
  input wire logic i_rx_en,
  input wire logic [CRW_NUM_CH*CRW_TX_SLICE_W-1:0] i_tx_wide,
  input wire logic [CRW_NUM_CH*CRW_RX_SLICE_W-1:0] i_rx_lane,
  input wire logic i_cfg_ready,
  output logic o_busy,
  output logic o_read_err,
  output logic o_cfg_valid,
  output logic [CRW_WORD_W-1:0] o_cfg_word,
  output logic [CRW_WIDX_W-1:0] o_cfg_widx,
  output logic [CRW_CH_SEL_W-1:0] o_cfg_ch,
  output logic [CRW_NUM_CH*20-1:0] o_tx_sym,
  output logic [CRW_NUM_CH*4-1:0] o_tx_ctrl,
  output logic [CRW_NUM_CH*4-1:0] o_tx_fdsp,
  output logic [CRW_NUM_CH*4-1:0] o_tx_dval,
  output logic [CRW_NUM_CH*CRW_RX_SLICE_W-1:0] o_rx_wide
);
  localparam int BW = CRW_WORD_W + CRW_WIDX_W + CRW_CH_SEL_W;

  // Image of the reconfiguration contents, loaded by the user side
  logic [CRW_WORD_W-1:0] img_r [CRW_NUM_WORDS];
  crw_state_t st_r, st_nxt;
  logic [CRW_WIDX_W-1:0] idx_r, idx_nxt;
  logic [CRW_CH_SEL_W-1:0] ch_r, ch_nxt;
  logic cont_r, cont_nxt;
  logic busy_r, busy_nxt;
  logic rerr_r, rerr_nxt;
  logic in_valid, in_ready, b_valid;
  logic [BW-1:0] b_data;
  logic cfg_valid_r, cfg_valid_nxt;
  logic [BW-1:0] cfg_r, cfg_nxt;
  logic last_word;
  logic last_prev_r, last_prev_nxt;

  always_ff @(posedge i_ref_clk) begin
    if (i_cfg_we && !busy_r) begin
      img_r[i_cfg_addr] <= i_cfg_word;
    end
  end

  assign last_word = (idx_r == CRW_WIDX_W'(CRW_NUM_WORDS - 1));

  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    ch_nxt = ch_r;
    cont_nxt = cont_r;
    busy_nxt = busy_r;
    last_prev_nxt = last_prev_r;
    in_valid = 1'b0;
    rerr_nxt = i_read;
    unique case (st_r)
      CRW_ST_IDLE: begin
        if (i_write_all && !i_read) begin
          st_nxt = CRW_ST_SEND;
          // Regular mode resumes at the next word unless the image was finished
          idx_nxt = (i_cont_mode || last_prev_r) ? CRW_WIDX_RST : idx_r;
          ch_nxt = i_ch_sel;
          cont_nxt = i_cont_mode;
          busy_nxt = 1'b1;
        end
      end
      CRW_ST_SEND: begin
        in_valid = 1'b1;
        if (in_ready) begin
          last_prev_nxt = last_word || cont_r;
          if (last_word) begin
            st_nxt = CRW_ST_WAIT;
          end else if (cont_r) begin
            idx_nxt = idx_r + 1'b1;
          end else begin
            idx_nxt = idx_r + 1'b1;
            st_nxt = CRW_ST_WAIT;
          end
        end
      end
      CRW_ST_WAIT: begin
        // Busy holds until the buffer and output stage drain to the channel
        if (!b_valid && !cfg_valid_r) begin
          busy_nxt = 1'b0;
          st_nxt = CRW_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= CRW_ST_IDLE;
      idx_r <= CRW_WIDX_RST;
      ch_r <= '0;
      cont_r <= 1'b0;
      busy_r <= 1'b0;
      rerr_r <= 1'b0;
      last_prev_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      ch_r <= ch_nxt;
      cont_r <= cont_nxt;
      busy_r <= busy_nxt;
      rerr_r <= rerr_nxt;
      last_prev_r <= last_prev_nxt;
    end
  end

  crw_skid_buf #(.W(BW)) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_valid(in_valid),
    .o_ready(in_ready),
    .i_data({ch_r, idx_r, img_r[idx_r]}),
    .o_valid(b_valid),
    .i_ready(!cfg_valid_r || i_cfg_ready),
    .o_data(b_data)
  );

  always_comb begin
    cfg_valid_nxt = cfg_valid_r;
    cfg_nxt = cfg_r;
    if (!cfg_valid_r || i_cfg_ready) begin
      cfg_valid_nxt = b_valid;
      cfg_nxt = b_valid ? b_data : cfg_r;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_valid_r <= 1'b0;
      cfg_r <= '0;
    end else begin
      cfg_valid_r <= cfg_valid_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign o_busy = busy_r;
  assign o_read_err = rerr_r;
  assign o_cfg_valid = cfg_valid_r;
  assign {o_cfg_ch, o_cfg_widx, o_cfg_word} = cfg_r;

  // Per-channel unpacking of the wide transmit word and gating of the receive word
  genvar g;
  generate
    for (g = 0; g < CRW_NUM_CH; g++) begin : g_ch
      logic [CRW_TX_SLICE_W-1:0] s;
      logic [19:0] sym_nxt, sym_r;
      logic [3:0] c_nxt, f_nxt, v_nxt, c_r, f_r, v_r;
      logic [CRW_RX_SLICE_W-1:0] rx_r;
      assign s = i_tx_wide[g*CRW_TX_SLICE_W +: CRW_TX_SLICE_W];
      always_comb begin
        sym_nxt = '0;
        c_nxt = '0;
        f_nxt = '0;
        v_nxt = '0;
        if (i_tx_en) begin
          unique case (i_if_width)
            CRW_IF_8: begin
              sym_nxt[7:0] = s[CRW_LO_DATA_LSB +: 8];
              if (i_enc_8b10b) begin
                c_nxt[0] = s[CRW_LO_CTRL_BIT];
                f_nxt[0] = s[CRW_LO_FDSP_BIT];
                v_nxt[0] = s[CRW_LO_DVAL_BIT];
              end
            end
            CRW_IF_10: sym_nxt[9:0] = s[CRW_LO_DATA_LSB +: 10];
            CRW_IF_16: begin
              sym_nxt[7:0] = s[CRW_LO_DATA_LSB +: 8];
              sym_nxt[17:10] = s[CRW_HI_DATA_LSB +: 8];
              if (i_enc_8b10b) begin
                c_nxt[1:0] = {s[CRW_HI_CTRL_BIT], s[CRW_LO_CTRL_BIT]};
                f_nxt[1:0] = {s[CRW_HI_FDSP_BIT], s[CRW_LO_FDSP_BIT]};
                v_nxt[1:0] = {s[CRW_HI_DVAL_BIT], s[CRW_LO_DVAL_BIT]};
              end
            end
            CRW_IF_20: begin
              sym_nxt[9:0] = s[CRW_LO_DATA_LSB +: 10];
              sym_nxt[19:10] = s[CRW_HI_DATA_LSB +: 10];
            end
          endcase
        end
      end
      always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          sym_r <= '0;
          c_r <= '0;
          f_r <= '0;
          v_r <= '0;
          rx_r <= '0;
        end else begin
          sym_r <= sym_nxt;
          c_r <= c_nxt;
          f_r <= f_nxt;
          v_r <= v_nxt;
          rx_r <= i_rx_en ? i_rx_lane[g*CRW_RX_SLICE_W +: CRW_RX_SLICE_W] : '0;
        end
      end
      assign o_tx_sym[g*20 +: 20] = sym_r;
      assign o_tx_ctrl[g*4 +: 4] = c_r;
      assign o_tx_fdsp[g*4 +: 4] = f_r;
      assign o_tx_dval[g*4 +: 4] = v_r;
      assign o_rx_wide[g*CRW_RX_SLICE_W +: CRW_RX_SLICE_W] = rx_r;
    end
  endgenerate

  AST_READ_IGNORED: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (st_r == CRW_ST_IDLE && i_read) |=> !busy_r && o_read_err)
    else $error("read request started a transaction");
  AST_BUSY_ON_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (st_r == CRW_ST_IDLE && i_write_all && !i_read) |=> busy_r)
    else $error("busy not raised after write-all");
  AST_CONT_STREAM: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (st_r == CRW_ST_SEND && cont_r && in_ready && !last_word) |=> st_r == CRW_ST_SEND)
    else $error("continuous write stopped early");
  AST_BUSY_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $fell(busy_r) |-> !o_cfg_valid && !b_valid && st_r == CRW_ST_IDLE)
    else $error("busy dropped before the words drained");
  AST_CFG_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_cfg_valid && !i_cfg_ready) |=> o_cfg_valid && $stable(o_cfg_word))
    else $error("word dropped under stall");
  AST_TX8: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_tx_en && i_if_width == CRW_IF_8) |=> o_tx_sym[7:0] == $past(i_tx_wide[7:0]))
    else $error("8-bit data misplaced");
  AST_TX20: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_tx_en && i_if_width == CRW_IF_20) |=> o_tx_sym[19:10] == $past(i_tx_wide[20:11]))
    else $error("20-bit high symbol misplaced");
  AST_RX_GATE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !i_rx_en |=> o_rx_wide == '0)
    else $error("receive word present without receiver");
endmodule

// file: crw_sink.sv
`timescale 1ns/1ps
module crw_sink
  import crw_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [CRW_WORD_W-1:0] i_word,
  input wire logic [CRW_WIDX_W-1:0] i_widx,
  input wire logic [CRW_CH_SEL_W-1:0] i_ch,
  output logic o_ready
);
  logic [CRW_WORD_W+CRW_WIDX_W+CRW_CH_SEL_W-1:0] got [$];
  logic [1:0] phase = 2'h0;
  // A slow channel takes one word in four, so the buffer fills behind it
  always @(negedge i_ref_clk) begin
    phase <= phase + 2'h1;
    o_ready <= !i_slow || (phase == 2'h3);
  end
  always @(posedge i_ref_clk) begin
    if (i_rstn && i_valid && o_ready) begin
      got.push_back({i_word, i_widx, i_ch});
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb
  import crw_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_all = 1'b0;
  logic rd = 1'b0;
  logic cont = 1'b0;
  logic we = 1'b0;
  logic slow = 1'b0;
  logic rx_en = 1'b1;
  logic enc = 1'b1;
  logic tx_en = 1'b1;
  logic [CRW_CH_SEL_W-1:0] ch = 1'h0;
  logic [CRW_WORD_W-1:0] word = 16'h0;
  logic [CRW_WIDX_W-1:0] addr = 4'h0;
  logic [1:0] mode = 2'h0;
  logic [CRW_NUM_CH*CRW_TX_SLICE_W-1:0] tx = 44'h0;
  logic [CRW_NUM_CH*CRW_RX_SLICE_W-1:0] rx = 64'h0;
  logic [CRW_WORD_W-1:0] img [CRW_NUM_WORDS];
  logic rdy, busy, rerr, cval;
  logic [CRW_WORD_W-1:0] cword;
  logic [CRW_WIDX_W-1:0] cidx;
  logic [CRW_CH_SEL_W-1:0] cch;
  logic [CRW_NUM_CH*20-1:0] sym;
  logic [CRW_NUM_CH*4-1:0] ctl, fds, dvl;
  logic [CRW_NUM_CH*CRW_RX_SLICE_W-1:0] rxw;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  crw_top u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_write_all(wr_all), .i_read(rd),
    .i_cont_mode(cont), .i_ch_sel(ch), .i_cfg_word(word), .i_cfg_addr(addr), .i_cfg_we(we),
    .i_if_width(mode), .i_enc_8b10b(enc), .i_tx_en(tx_en), .i_rx_en(rx_en), .i_tx_wide(tx),
    .i_rx_lane(rx), .i_cfg_ready(rdy), .o_busy(busy), .o_read_err(rerr), .o_cfg_valid(cval),
    .o_cfg_word(cword), .o_cfg_widx(cidx), .o_cfg_ch(cch), .o_tx_sym(sym), .o_tx_ctrl(ctl),
    .o_tx_fdsp(fds), .o_tx_dval(dvl), .o_rx_wide(rxw));
  crw_sink u_sink (.i_ref_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_valid(cval),
    .i_word(cword), .i_widx(cidx), .i_ch(cch), .o_ready(rdy));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (exp !== got) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic trig(input logic [CRW_CH_SEL_W-1:0] c);
    @(negedge clk);
    ch = c;
    wr_all = 1'b1;
    @(negedge clk);
    wr_all = 1'b0;
    @(negedge clk);
    chk("busy_high", 1'h1, busy);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("busy_low", 1'h0, busy);
  endtask
  task automatic chk_got(input int first, input int cnt, input logic [CRW_CH_SEL_W-1:0] c);
    chk("word_count", 64'(cnt), 64'(u_sink.got.size()));
    for (int i = 0; i < cnt && i < u_sink.got.size(); i++) begin
      chk("word", {img[(first + i) % 16], 4'(first + i), c}, u_sink.got[i]);
    end
    u_sink.got.delete();
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    logic [CRW_TX_SLICE_W-1:0] s;
    for (int i = 0; i < CRW_NUM_WORDS; i++) begin
      img[i] = 16'h9c31 + 16'h1357 * 16'(i);
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    chk("busy_rst", 1'h0, busy);
    chk("valid_rst", 1'h0, cval);
    for (int i = 0; i < CRW_NUM_WORDS; i++) begin
      @(negedge clk);
      we = 1'b1;
      addr = 4'(i);
      word = img[i];
    end
    @(negedge clk);
    we = 1'b0;
    $display("test reset and load done");
    // Regular mode: one word per trigger, index moves on each time
    for (int k = 0; k < 3; k++) begin
      trig(1'h0);
      wait_idle();
      chk_got(k, 1, 1'h0);
    end
    $display("test regular done");
    // Second reset restarts the index; the image itself is kept
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    trig(1'h1);
    wait_idle();
    chk_got(0, 1, 1'h1);
    cont = 1'b1;
    slow = 1'b1;
    trig(1'h1);
    wait_idle();
    chk_got(0, 16, 1'h1);
    $display("test continuous done");
    @(negedge clk);
    rd = 1'b1;
    wr_all = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    wr_all = 1'b0;
    chk("read_flag", 1'h1, rerr);
    chk("read_busy", 1'h0, busy);
    @(negedge clk);
    chk("read_nodata", 1'h0, cval);
    $display("test read refused done");
    tx = {22'h15a3c9, 22'h2b5a5c};
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m);
      @(negedge clk);
      @(negedge clk);
      for (int c = 0; c < CRW_NUM_CH; c++) begin
        s = tx[c*CRW_TX_SLICE_W +: CRW_TX_SLICE_W];
        if (mode == CRW_IF_8) begin
          chk("sym8", s[7:0], sym[c*20 +: 8]);
          chk("flags8", {s[10], s[9], s[8]}, {dvl[c*4], fds[c*4], ctl[c*4]});
          chk("sym8hi", 12'h0, sym[c*20+8 +: 12]);
        end else if (mode == CRW_IF_10) begin
          chk("sym10", s[9:0], sym[c*20 +: 10]);
          chk("ctrl10", 4'h0, ctl[c*4 +: 4]);
        end else if (mode == CRW_IF_16) begin
          chk("sym16", s[7:0], sym[c*20 +: 8]);
          chk("sym16hi", s[18:11], sym[c*20+10 +: 8]);
          chk("flags16", {s[21], s[10], s[20], s[9], s[19], s[8]},
            {dvl[c*4 +: 2], fds[c*4 +: 2], ctl[c*4 +: 2]});
        end else begin
          chk("sym20", {s[20:11], s[9:0]}, sym[c*20 +: 20]);
          chk("flags20", 12'h0, {dvl[c*4 +: 4], fds[c*4 +: 4], ctl[c*4 +: 4]});
        end
      end
    end
    // Without 8B/10B the flag bits of the slice are unused
    mode = CRW_IF_16;
    enc = 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk("flags_plain", 24'h0, {dvl, fds, ctl});
    tx_en = 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk("tx_off", 40'h0, sym);
    $display("test transmit packing done");
    rx = 64'h0123_4567_89ab_cdef;
    @(negedge clk);
    @(negedge clk);
    chk("rx_on", rx, rxw);
    rx_en = 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk("rx_off", 64'h0, rxw);
    $display("test receive done");
    end_of_test();
  end
endmodule
